/* logic/rrl_params.svh */
`ifndef RRL_PARAMS_SVH
`define RRL_PARAMS_SVH

// Behaviour
// R1 - List holds an entry count from 0 to 30 and up to thirty identities.
// R2 - Slot 0 holds the newest identity and ages grow toward slot 29.
// R3 - A new rejection goes into slot 0 and pushes older entries down.
// R4 - Entries beyond 30 drop off the oldest end; count never exceeds 30.
// R5 - A re-rejected identity moves to slot 0 without leaving a duplicate.
// R6 - A registration acknowledgement removes the identity, closes the gap, decrements count.
// R7 - Only slots below the count take part in matching.
// R8 - Registration on a network found in the valid list is blocked automatically.
// R9 - A listed network is permitted only with the user override request.
// R10 - Control byte: b7..b3 reserved zero, b2 international, b1 domestic, b0 home group.
// R11 - Zero control bits allow home only; each set bit adds its network class.
// R12 - Networks barred by the control byte stay barred even with user override.
// R13 - Control-allowed but listed networks are accessed only with user override.
// R14 - The list file may be absent only for control byte 00 or 01.
// R15 - Card lets user PIN level read and update the list file 6F 53.
// R16 - Card control file 6F 54 is user readable, administrative level writable.
// R17 - One clock, synchronous reset clears the count, one operation per handshake.

// List geometry.
`define RRL_MAX_COUNT      5'h1e
`define RRL_LAST_IDX       5'h1d
`define RRL_FIRST_IDX      5'h00
`define RRL_ID_W           16
`define RRL_IDX_W          5

// Control byte layout.
`define RRL_CTRL_INTL_BIT  2
`define RRL_CTRL_DOM_BIT   1
`define RRL_CTRL_GRP_BIT   0
`define RRL_CTRL_RSVD_MASK 8'hf8
`define RRL_CTRL_NOLIST_A  8'h00
`define RRL_CTRL_NOLIST_B  8'h01

// Reset values.
`define RRL_COUNT_RST      5'h00
`define RRL_ID_RST         16'h0000

`endif

/* logic/rrl_pkg.sv */
`include "rrl_params.svh"

package rrl_pkg;

  // Operations taken on the request handshake.
  typedef enum logic [1:0] {
    RRL_OP_LOOKUP = 2'h0,
    RRL_OP_INSERT = 2'h1,
    RRL_OP_DELETE = 2'h2,
    RRL_OP_LOAD   = 2'h3
  } rrl_op_type;

  // Class of the candidate network relative to the subscriber.
  typedef enum logic [1:0] {
    RRL_CLASS_HOME     = 2'h0,
    RRL_CLASS_GROUP    = 2'h1,
    RRL_CLASS_DOMESTIC = 2'h2,
    RRL_CLASS_INTL     = 2'h3
  } rrl_class_type;

  // Sequencer states, Gray coded along idle, match, apply.
  typedef enum logic [1:0] {
    RRL_ST_IDLE  = 2'h0,
    RRL_ST_MATCH = 2'h1,
    RRL_ST_APPLY = 2'h3
  } rrl_state_type;

  typedef struct packed {
    rrl_op_type              op;
    logic [`RRL_ID_W-1:0]    id;
    rrl_class_type           net_class;
    logic                    override;
    logic [`RRL_IDX_W-1:0]   slot;
    logic [`RRL_IDX_W-1:0]   load_count;
  } rrl_req_type;

  typedef struct packed {
    logic                    allow;
    logic                    needs_user;
    logic                    forbid;
    logic                    hit;
    logic [`RRL_IDX_W-1:0]   hit_idx;
    logic [`RRL_IDX_W-1:0]   count;
  } rrl_resp_type;

endpackage

/* logic/rrl_roam_decode.sv */
`include "rrl_params.svh"

// Decodes the roaming control byte for one network class.
module rrl_roam_decode (
  // Control byte and candidate class
  input  wire logic [7:0]             ctrl_byte,
  input  wire rrl_pkg::rrl_class_type net_class,
  // Decoded results
  output logic                        class_allowed,
  output logic                        list_required,
  output logic                        reserved_bad
);

  // Home is always reachable; every other class needs its own bit.
  always_comb begin
    unique case (net_class)
      rrl_pkg::RRL_CLASS_HOME:     class_allowed = 1'b1; // R11
      rrl_pkg::RRL_CLASS_GROUP:    class_allowed = ctrl_byte[`RRL_CTRL_GRP_BIT]; // R10
      rrl_pkg::RRL_CLASS_DOMESTIC: class_allowed = ctrl_byte[`RRL_CTRL_DOM_BIT]; // R10
      rrl_pkg::RRL_CLASS_INTL:     class_allowed = ctrl_byte[`RRL_CTRL_INTL_BIT]; // R10
    endcase
  end

  // Only the two home-bound settings may run without the list file.
  assign list_required = (ctrl_byte != `RRL_CTRL_NOLIST_A) && (ctrl_byte != `RRL_CTRL_NOLIST_B); // R14
  assign reserved_bad  = |(ctrl_byte & `RRL_CTRL_RSVD_MASK); // R10

endmodule

/* logic/rrl_filter.sv */
`include "rrl_params.svh"

// Rejected-network list with roaming verdict for the mobile terminal.
module rrl_filter (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         reset,
  // Request handshake
  input  wire logic                         req_valid,
  input  wire rrl_pkg::rrl_req_type         req,
  output logic                              req_ready_r,
  // Response
  output logic                              resp_valid_r,
  output rrl_pkg::rrl_resp_type             resp_r,
  // Card file configuration
  input  wire logic [7:0]                   ctrl_byte,
  input  wire logic                         list_present,
  // Status
  output logic [`RRL_IDX_W-1:0]             count_r,
  output logic                              list_missing_r,
  output logic                              ctrl_reserved_r,
  // Slot read-back for writing the file image back to the card
  input  wire logic [`RRL_IDX_W-1:0]        rd_idx,
  output logic [`RRL_ID_W-1:0]              rd_id_r
);

  rrl_pkg::rrl_state_type  state_r;
  rrl_pkg::rrl_state_type  state_nxt;
  rrl_pkg::rrl_req_type    cur_r;
  logic [`RRL_ID_W-1:0]    slots_r [30];
  logic [29:0]             hit_vec;
  logic                    hit_r;
  logic [`RRL_IDX_W-1:0]   hit_idx_r;
  logic [`RRL_IDX_W-1:0]   count_nxt;
  logic                    class_allowed;
  logic                    list_required;
  logic                    reserved_bad;
  logic                    listed;
  logic                    take;

  // Lowest set position of a hit vector; only a load, or an insert while the list file is absent,
  // can put a duplicate in the list, so otherwise the lowest hit is the only one.
  function automatic logic [`RRL_IDX_W-1:0] rrl_first(input logic [29:0] vec);
    logic [`RRL_IDX_W-1:0] idx;
    idx = `RRL_FIRST_IDX;
    for (int k = 29; k >= 0; k--) begin
      if (vec[k]) begin
        idx = 5'(k);
      end
    end
    return idx;
  endfunction

  rrl_roam_decode u_decode (
    .ctrl_byte     (ctrl_byte),
    .net_class     (cur_r.net_class),
    .class_allowed (class_allowed),
    .list_required (list_required),
    .reserved_bad  (reserved_bad)
  );

  assign take = req_valid && req_ready_r;

  // Compare only the slots below the count; stale data past it is ignored.
  generate
    for (genvar g = 0; g < 30; g++) begin : g_hit
      assign hit_vec[g] = (5'(g) < count_r) && (slots_r[g] == cur_r.id); // R7
    end
  endgenerate

  // Sequencer: idle, match, apply, back to idle.
  always_comb begin
    unique case (state_r)
      rrl_pkg::RRL_ST_IDLE:  state_nxt = take ? rrl_pkg::RRL_ST_MATCH : rrl_pkg::RRL_ST_IDLE;
      rrl_pkg::RRL_ST_MATCH: state_nxt = rrl_pkg::RRL_ST_APPLY;
      rrl_pkg::RRL_ST_APPLY: state_nxt = rrl_pkg::RRL_ST_IDLE;
      default:               state_nxt = rrl_pkg::RRL_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r     <= rrl_pkg::RRL_ST_IDLE;
      req_ready_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      req_ready_r <= (state_nxt == rrl_pkg::RRL_ST_IDLE); // R17
    end
  end

  // Capture the request so the list sees a stable operand for the whole pass.
  always_ff @(posedge mclk) begin
    if (reset) begin
      cur_r <= '0;
    end else if (take) begin
      cur_r <= req; // R17
    end
  end

  // Register the match so the shift network is not chained behind 30 comparators.
  always_ff @(posedge mclk) begin
    if (reset) begin
      hit_r     <= 1'b0;
      hit_idx_r <= `RRL_FIRST_IDX;
    end else if (state_r == rrl_pkg::RRL_ST_MATCH) begin
      hit_r     <= (|hit_vec) && list_present;
      hit_idx_r <= rrl_first(hit_vec);
    end
  end

  // Count after the operation; a full list stays full because the oldest drops off.
  always_comb begin
    count_nxt = count_r;
    unique case (cur_r.op)
      rrl_pkg::RRL_OP_INSERT: begin
        if (!hit_r && (count_r < `RRL_MAX_COUNT)) begin
          count_nxt = count_r + 5'h01; // R4
        end
      end
      rrl_pkg::RRL_OP_DELETE: begin
        if (hit_r) begin
          count_nxt = count_r - 5'h01; // R6
        end
      end
      rrl_pkg::RRL_OP_LOAD: begin
        count_nxt = (cur_r.load_count > `RRL_MAX_COUNT) ? `RRL_MAX_COUNT : cur_r.load_count; // R1
      end
      rrl_pkg::RRL_OP_LOOKUP: begin
        count_nxt = count_r;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      count_r <= `RRL_COUNT_RST; // R17
    end else if (state_r == rrl_pkg::RRL_ST_APPLY) begin
      count_r <= count_nxt;
    end
  end

  // Slot 0 always receives the newest identity.
  always_ff @(posedge mclk) begin
    if (reset) begin
      slots_r[0] <= `RRL_ID_RST;
    end else if (state_r == rrl_pkg::RRL_ST_APPLY) begin
      if (cur_r.op == rrl_pkg::RRL_OP_INSERT) begin
        slots_r[0] <= cur_r.id; // R2
      end else if ((cur_r.op == rrl_pkg::RRL_OP_DELETE) && hit_r && (hit_idx_r == 5'h00)) begin
        slots_r[0] <= slots_r[1]; // R6
      end else if ((cur_r.op == rrl_pkg::RRL_OP_LOAD) && (cur_r.slot == 5'h00)) begin
        slots_r[0] <= cur_r.id;
      end
    end
  end

  // Older slots shift down on insert and up on delete. On a re-rejection the
  // shift stops at the old position, which removes the duplicate in the same pass.
  generate
    for (genvar g = 1; g < 30; g++) begin : g_slot
      localparam logic [`RRL_IDX_W-1:0] IDX = 5'(g);
      always_ff @(posedge mclk) begin
        if (reset) begin
          slots_r[g] <= `RRL_ID_RST;
        end else if (state_r == rrl_pkg::RRL_ST_APPLY) begin
          if ((cur_r.op == rrl_pkg::RRL_OP_INSERT) && (!hit_r || (IDX <= hit_idx_r))) begin
            slots_r[g] <= slots_r[g-1]; // R3 R5
          end else if ((cur_r.op == rrl_pkg::RRL_OP_DELETE) && hit_r && (IDX >= hit_idx_r) && (g < 29)) begin
            slots_r[g] <= slots_r[(g < 29) ? g + 1 : g]; // R6
          end else if ((cur_r.op == rrl_pkg::RRL_OP_LOAD) && (cur_r.slot == IDX)) begin
            slots_r[g] <= cur_r.id;
          end
        end
      end
    end
  endgenerate

  // Verdict: the control byte is absolute, the list only asks for the user.
  assign listed = hit_r; // R8

  always_ff @(posedge mclk) begin
    if (reset) begin
      resp_valid_r <= 1'b0;
      resp_r       <= '0;
    end else begin
      resp_valid_r <= (state_r == rrl_pkg::RRL_ST_APPLY);
      if (state_r == rrl_pkg::RRL_ST_APPLY) begin
        resp_r.forbid     <= !class_allowed; // R12
        resp_r.allow      <= class_allowed && (!listed || cur_r.override); // R9 R13
        resp_r.needs_user <= class_allowed && listed && !cur_r.override; // R8
        resp_r.hit        <= hit_r;
        resp_r.hit_idx    <= hit_idx_r;
        resp_r.count      <= count_nxt;
      end
    end
  end

  // Configuration status; a missing list file is only legal for 00 and 01.
  always_ff @(posedge mclk) begin
    if (reset) begin
      list_missing_r  <= 1'b0;
      ctrl_reserved_r <= 1'b0;
    end else begin
      list_missing_r  <= list_required && !list_present; // R14
      ctrl_reserved_r <= reserved_bad; // R10
    end
  end

  // Raw read-back; indices past the last slot read as zero.
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_id_r <= `RRL_ID_RST;
    end else begin
      rd_id_r <= (rd_idx <= `RRL_LAST_IDX) ? slots_r[rd_idx] : `RRL_ID_RST;
    end
  end

  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_ins_apply;
    (state_r == rrl_pkg::RRL_ST_APPLY) && (cur_r.op == rrl_pkg::RRL_OP_INSERT);
  endsequence

  sequence s_del_hit;
    (state_r == rrl_pkg::RRL_ST_APPLY) && (cur_r.op == rrl_pkg::RRL_OP_DELETE) && hit_r;
  endsequence

  sequence s_pass;
    (state_r == rrl_pkg::RRL_ST_MATCH) ##1 (state_r == rrl_pkg::RRL_ST_APPLY) ##1 resp_valid_r;
  endsequence

  sequence s_apply;
    state_r == rrl_pkg::RRL_ST_APPLY;
  endsequence

  AST_COUNT_MAX: assert property (count_r <= `RRL_MAX_COUNT) // R1
    else $error("Entry count above thirty.");
  AST_INSERT_TOP: assert property (s_ins_apply |=> slots_r[0] == $past(cur_r.id)) // R2
    else $error("Inserted identity not in slot zero.");
  AST_INSERT_SHIFT: assert property (s_ins_apply and !hit_r |=> slots_r[1] == $past(slots_r[0])) // R3
    else $error("Old newest entry not shifted to slot one.");
  AST_INSERT_GROW: assert property (s_ins_apply and !hit_r |=> // R4
                                    count_r == (($past(count_r) == `RRL_MAX_COUNT) ?
                                    `RRL_MAX_COUNT : $past(count_r) + 5'h01))
    else $error("Count wrong after new insert.");
  AST_REINSERT_SAME: assert property (s_ins_apply and hit_r |=> $stable(count_r)) // R5
    else $error("Re-rejection changed the count.");
  AST_DELETE_SHRINK: assert property (s_del_hit |=> count_r == $past(count_r) - 5'h01) // R6
    else $error("Delete did not decrement the count.");
  AST_HIT_VALID: assert property ((state_r == rrl_pkg::RRL_ST_MATCH) |=> !hit_r || (hit_idx_r < count_r)) // R7
    else $error("Match reported beyond the valid count.");
  AST_BARRED: assert property ((state_r == rrl_pkg::RRL_ST_APPLY) && !class_allowed // R12
                               |=> resp_valid_r && resp_r.forbid && !resp_r.allow)
    else $error("Barred network was allowed.");
  AST_LISTED_USER: assert property ((state_r == rrl_pkg::RRL_ST_APPLY) && class_allowed && hit_r // R13
                                    && !cur_r.override |=> !resp_r.allow && resp_r.needs_user)
    else $error("Listed network allowed without override.");
  AST_LATENCY: assert property (take |=> s_pass) // R17
    else $error("Request did not complete in three cycles.");
  AST_MISSING: assert property (!list_present && (ctrl_byte > `RRL_CTRL_NOLIST_B) |=> list_missing_r) // R14
    else $error("Missing list file not flagged.");

  // Handshake shape: ready drops for the two working cycles and the answer is a single pulse.
  sequence s_busy;
    !req_ready_r ##1 !req_ready_r ##1 req_ready_r;
  endsequence

  AST_READY_BUSY: assert property (take |=> s_busy) // R17
    else $error("Ready not low while a request is worked.");
  AST_RESP_PULSE: assert property (resp_valid_r |=> !resp_valid_r) // R17
    else $error("Response valid held beyond one cycle.");

  // Shift network: every gap that a move or a removal opens is closed in the same pass.
  AST_DELETE_CLOSE: assert property (s_del_hit and (hit_idx_r < `RRL_LAST_IDX) |=> // R6
                                     slots_r[hit_idx_r] == $past(slots_r[hit_idx_r + 5'h01]))
    else $error("Delete left a gap in the list.");
  AST_REINSERT_CLOSE: assert property (s_ins_apply and hit_r and (hit_idx_r != `RRL_FIRST_IDX) |=> // R5
                                       slots_r[hit_idx_r] == $past(slots_r[hit_idx_r - 5'h01]))
    else $error("Re-rejection left the old entry in place.");
  AST_OVERFLOW_DROP: assert property (s_ins_apply and !hit_r and (count_r == `RRL_MAX_COUNT) |=> // R4
                                      slots_r[`RRL_LAST_IDX] == $past(slots_r[`RRL_LAST_IDX - 5'h01]))
    else $error("Full list did not drop its oldest entry.");
  AST_NOLIST_NOHIT: assert property ((state_r == rrl_pkg::RRL_ST_MATCH) && !list_present |=> !hit_r) // R14
    else $error("Match reported while the list file is absent.");

  // Verdict: home is always open, every other class follows its own control bit, and the list only asks for the user.
  AST_HOME_OPEN: assert property (s_apply and (cur_r.net_class == rrl_pkg::RRL_CLASS_HOME) |=> // R11
                                  !resp_r.forbid)
    else $error("Home network was barred.");
  AST_GROUP_BIT: assert property (s_apply and (cur_r.net_class == rrl_pkg::RRL_CLASS_GROUP) |=> // R10
                                  resp_r.forbid != $past(ctrl_byte[`RRL_CTRL_GRP_BIT]))
    else $error("Home group verdict does not follow its control bit.");
  AST_DOM_BIT: assert property (s_apply and (cur_r.net_class == rrl_pkg::RRL_CLASS_DOMESTIC) |=> // R10
                                resp_r.forbid != $past(ctrl_byte[`RRL_CTRL_DOM_BIT]))
    else $error("Domestic verdict does not follow its control bit.");
  AST_INTL_BIT: assert property (s_apply and (cur_r.net_class == rrl_pkg::RRL_CLASS_INTL) |=> // R10
                                 resp_r.forbid != $past(ctrl_byte[`RRL_CTRL_INTL_BIT]))
    else $error("International verdict does not follow its control bit.");
  AST_OVERRIDE: assert property (s_apply and class_allowed and hit_r and cur_r.override |=> // R9
                                 resp_r.allow && !resp_r.needs_user)
    else $error("Override did not admit a listed network.");
  AST_UNLISTED: assert property (s_apply and class_allowed and !hit_r |=> // R11
                                 resp_r.allow && !resp_r.needs_user && !resp_r.forbid)
    else $error("Unlisted allowed network was not admitted.");
  AST_LISTED_BLOCK: assert property (s_apply and hit_r and !cur_r.override |=> !resp_r.allow) // R8
    else $error("Listed network admitted automatically.");

endmodule

/* verification/rrl_card_model.sv */
// Card file storage as the filter sees it: the control file and the list file presence.
module rrl_card_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // File update from the terminal
  input  wire logic        wr_en,
  input  wire logic        wr_admin,
  input  wire logic [15:0] wr_file,
  input  wire logic [7:0]  wr_data,
  // File contents seen by the filter
  output logic [7:0]       ctrl_byte_r,
  output logic             list_present_r
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [15:0] LIST_FILE = 16'h6f53;
  localparam logic [15:0] CTRL_FILE = 16'h6f54;

  // The control file only changes at administrative level; user writes are silently dropped.
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_byte_r <= 8'h00;
    end else if (wr_en && wr_admin && wr_file == CTRL_FILE) begin
      ctrl_byte_r <= wr_data;
    end
  end

  // Invalidation and rehabilitation of the list file also need administrative level.
  always_ff @(posedge mclk) begin
    if (reset) begin
      list_present_r <= 1'b1;
    end else if (wr_en && wr_admin && wr_file == LIST_FILE) begin
      list_present_r <= wr_data[0];
    end
  end
endmodule

/* verification/tb_roaming_reject_list_filter.sv */
module tb_roaming_reject_list_filter;
  timeunit 1ns;
  timeprecision 1ns;

  localparam rrl_pkg::rrl_op_type LKP       = rrl_pkg::RRL_OP_LOOKUP;
  localparam rrl_pkg::rrl_op_type INS       = rrl_pkg::RRL_OP_INSERT;
  localparam rrl_pkg::rrl_op_type DEL       = rrl_pkg::RRL_OP_DELETE;
  localparam rrl_pkg::rrl_op_type LDS       = rrl_pkg::RRL_OP_LOAD;
  localparam logic [15:0]         LIST_FILE = 16'h6f53;
  localparam logic [15:0]         CTRL_FILE = 16'h6f54;

  logic                  mclk, reset, req_valid, req_ready_r, resp_valid_r;
  logic                  list_missing_r, ctrl_reserved_r, wr_en, wr_admin, list_present_r;
  logic [4:0]            count_r, rd_idx;
  logic [7:0]            ctrl_byte_r, wr_data;
  logic [15:0]           wr_file, rd_id_r;
  rrl_pkg::rrl_req_type  req;
  rrl_pkg::rrl_resp_type resp_r;
  int                    n_fail, n_tests;

  // Free-running system clock.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  rrl_filter DUT (.mclk(mclk), .reset(reset), .req_valid(req_valid), .req(req), .req_ready_r(req_ready_r),
    .resp_valid_r(resp_valid_r), .resp_r(resp_r), .ctrl_byte(ctrl_byte_r), .list_present(list_present_r),
    .count_r(count_r), .list_missing_r(list_missing_r), .ctrl_reserved_r(ctrl_reserved_r), .rd_idx(rd_idx),
    .rd_id_r(rd_id_r));

  rrl_card_model card_model (.mclk(mclk), .reset(reset), .wr_en(wr_en), .wr_admin(wr_admin), .wr_file(wr_file),
    .wr_data(wr_data), .ctrl_byte_r(ctrl_byte_r), .list_present_r(list_present_r));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One handshake; the request is held until the edge where ready is high, then dropped.
  task automatic op(input rrl_pkg::rrl_op_type o, input logic [15:0] id, input logic [1:0] cls = 2'h0,
                    input logic ovr = 1'b0, input logic [4:0] sl = 5'h00, input logic [4:0] lc = 5'h00);
    int n;
    @(negedge mclk);
    req = '{o, id, rrl_pkg::rrl_class_type'(cls), ovr, sl, lc};
    req_valid = 1'b1;
    for (n = 0; req_ready_r !== 1'b1 && n < 20; n++) @(negedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
    for (n = 1; resp_valid_r !== 1'b1 && n < 20; n++) @(negedge mclk);
    chk("response latency", 16'h3, 16'(n));
  endtask

  task automatic rd(input logic [4:0] i, input logic [15:0] exp);
    @(negedge mclk);
    rd_idx = i;
    @(negedge mclk);
    chk("rd_id_r", exp, rd_id_r);
  endtask

  task automatic card(input logic administrative_level, input logic [15:0] f, input logic [7:0] d);
    @(negedge mclk);
    wr_en = 1'b1;
    wr_admin = administrative_level;
    wr_file = f;
    wr_data = d;
    @(negedge mclk);
    wr_en = 1'b0;
  endtask

  // Newest first, re-rejection moves to the top, acknowledgement closes the gap.
  task automatic t_order;
    op(INS, 16'h1001);
    op(INS, 16'h1002);
    op(INS, 16'h1003);
    chk("count_r", 16'h3, 16'(count_r));
    rd(5'h00, 16'h1003);
    rd(5'h01, 16'h1002);
    rd(5'h02, 16'h1001);
    op(INS, 16'h1001);
    chk("count_r", 16'h3, 16'(count_r));
    rd(5'h00, 16'h1001);
    rd(5'h02, 16'h1002);
    op(DEL, 16'h1003);
    chk("hit", 16'h1, 16'(resp_r.hit));
    chk("count_r", 16'h2, 16'(count_r));
    rd(5'h01, 16'h1002);
    op(DEL, 16'h5555);
    chk("count_r", 16'h2, 16'(resp_r.count));
  endtask

  // Overflow drops the oldest, then a re-rejection at the full boundary.
  task automatic t_full;
    for (int i = 0; i < 31; i++) op(INS, 16'h2000 + 16'(i));
    chk("count_r", 16'h1e, 16'(count_r));
    rd(5'h00, 16'h201e);
    rd(5'h1d, 16'h2001);
    op(LKP, 16'h1001);
    chk("hit", 16'h0, 16'(resp_r.hit));
    op(INS, 16'h2001);
    chk("count_r", 16'h1e, 16'(count_r));
    rd(5'h00, 16'h2001);
    rd(5'h1d, 16'h2002);
  endtask

  // Slots beyond the count never match; a count above thirty is clamped.
  task automatic t_valid;
    op(LDS, 16'h3333, 2'h0, 1'b0, 5'h03, 5'h02);
    chk("count_r", 16'h2, 16'(count_r));
    op(LKP, 16'h3333);
    chk("hit", 16'h0, 16'(resp_r.hit));
    op(LDS, 16'h3333, 2'h0, 1'b0, 5'h03, 5'h1f);
    chk("count_r", 16'h1e, 16'(count_r));
    op(LKP, 16'h3333);
    chk("hit_idx", 16'h3, {resp_r.hit, 10'h0, resp_r.hit_idx} ^ 16'h8000);
  endtask

  // All eight settings of control bits b2..b0 against every class, listed without and with override, and unlisted.
  task automatic t_verdict;
    logic al;
    for (int c = 0; c < 8; c++) begin
      card(1'b1, CTRL_FILE, 8'(c));
      for (int k = 0; k < 4; k++) begin
        al = (k == 0) ? 1'b1 : c[k-1];
        for (int m = 0; m < 3; m++) begin
          op(LKP, (m == 2) ? 16'h7777 : 16'h3333, k[1:0], m == 1);
          chk("verdict", {13'h0, al && m != 0, al && m == 0, !al},
              {13'h0, resp_r.allow, resp_r.needs_user, resp_r.forbid});
        end
      end
    end
  endtask

  // Access levels of the card files and the missing-list check.
  task automatic t_file;
    logic [7:0] v [4] = '{8'h00, 8'h01, 8'h02, 8'hf9};
    card(1'b1, CTRL_FILE, 8'h03);
    card(1'b0, CTRL_FILE, 8'h05);
    chk("ctrl_byte_r", 16'h3, 16'(ctrl_byte_r));
    card(1'b0, LIST_FILE, 8'h00);
    chk("list_present_r", 16'h1, 16'(list_present_r));
    card(1'b1, LIST_FILE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      card(1'b1, CTRL_FILE, v[i]);
      @(negedge mclk);
      chk("list_missing_r", {15'h0, v[i] > 8'h01}, list_missing_r);
      chk("ctrl_reserved_r", {15'h0, |v[i][7:3]}, ctrl_reserved_r);
    end
    op(LKP, 16'h3333);
    chk("hit", 16'h0, 16'(resp_r.hit));
    card(1'b1, LIST_FILE, 8'h01);
  endtask

  // Main sequence: reset, then the scenarios in turn.
  initial begin
    n_fail = 0;
    n_tests = 0;
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    rd_idx = 5'h00;
    wr_en = 1'b0;
    wr_admin = 1'b0;
    wr_file = 16'h0000;
    wr_data = 8'h00;
    repeat (10) @(negedge mclk);
    chk("req_ready_r", 16'h0, 16'(req_ready_r));
    chk("count_r", 16'h0, 16'(count_r));
    reset = 1'b0;
    @(negedge mclk);
    chk("req_ready_r", 16'h1, 16'(req_ready_r));
    card(1'b1, CTRL_FILE, 8'h07);
    t_order();
    t_full();
    t_valid();
    t_verdict();
    t_file();
    conclude();
  end

  // Cuts a hung run short; the span is several times what the scenarios need.
  initial begin
    repeat (8000) @(posedge mclk);
    n_fail++;
    $display("Error watchdog expected done seen timeout");
    conclude();
  end
endmodule
